// File: common/port_abd_mux_pkg.sv
// Constants and types for the port A/B/D pin function multiplexer
package port_abd_mux_pkg;

    // ************************************************************
    // Interface configuration field encodings
    // ************************************************************
    localparam int IFC_W = 2;
    localparam logic [IFC_W-1:0] IFC_PORTS = 2'h0;
    localparam logic [IFC_W-1:0] IFC_RESERVED = 2'h1;
    localparam logic [IFC_W-1:0] IFC_GPIF = 2'h2;
    localparam logic [IFC_W-1:0] IFC_SLAVE_FIFO = 2'h3;

    // ************************************************************
    // Reset values of the configuration bits
    // ************************************************************
    localparam logic [IFC_W-1:0] IFC_RESET = IFC_PORTS;
    localparam logic ALT_CONFIG7_RESET = 1'h0;
    localparam logic PIN_POLARITY5_RESET = 1'h0;
    localparam logic WORDWIDE_RESET = 1'h0;
    localparam logic NAND_MODE_RESET = 1'h0;

    // ************************************************************
    // Pin group widths and synchroniser bit positions
    // ************************************************************
    localparam int PORTB_W = 8;
    localparam int PORTA_W = 2;
    localparam int FIFO_DATA_W = 9;
    localparam int SYNC_W = 11;
    localparam int SYNC_PA6 = 0;
    localparam int SYNC_PA7 = 1;
    localparam int SYNC_PB_LSB = 2;
    localparam int SYNC_PD0 = 10;
    localparam int PA_SIX = 0;
    localparam int PA_SEVEN = 1;
    localparam int FIFO_BIT_EIGHT = 8;

    // ************************************************************
    // Pin function modes
    // ************************************************************
    typedef enum logic [3:0] {
        MODE_PORT = 4'b0001,
        MODE_NAND = 4'b0010,
        MODE_GPIF = 4'b0100,
        MODE_SLAVE = 4'b1000
    } pin_mode_t;

    // Mode chosen by the interface field and the firmware NAND role
    function automatic pin_mode_t decode_mode(input logic [IFC_W-1:0] ifc, input logic nand_en);
        pin_mode_t m;
        m = MODE_PORT;
        unique case (ifc)
            IFC_GPIF: begin
                m = MODE_GPIF;
            end
            IFC_SLAVE_FIFO: begin
                m = MODE_SLAVE;
            end
            IFC_PORTS, IFC_RESERVED: begin
                m = nand_en ? MODE_NAND : MODE_PORT;
            end
        endcase
        return m;
    endfunction

endpackage

// File: hw/pin_input_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb begin
        state_d.meta = async_i;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stable;

endmodule

`default_nettype wire

// File: hw/port_abd_function_mux.sv
// Pin function multiplexer for port A bits 6-7, port B and port D bit 0
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// ************************************************************

module port_abd_function_mux #(
    parameter int STROBE_W = 4
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Configuration load
    input wire logic cfg_load_i,
    input wire logic [port_abd_mux_pkg::IFC_W-1:0] cfg_interface_config_i,
    input wire logic cfg_porta_alt_config7_i,
    input wire logic cfg_fifo_pin_polarity5_i,
    input wire logic cfg_endpoint_wordwide_i,
    input wire logic cfg_nand_mode_i,
    output logic [3:0] active_mode_o,
    // Port I/O side
    input wire logic [port_abd_mux_pkg::PORTA_W-1:0] porta_out_i,
    input wire logic [port_abd_mux_pkg::PORTA_W-1:0] porta_dir_i,
    input wire logic [port_abd_mux_pkg::PORTB_W-1:0] portb_out_i,
    input wire logic [port_abd_mux_pkg::PORTB_W-1:0] portb_dir_i,
    input wire logic portd_out_i,
    input wire logic portd_dir_i,
    output logic [port_abd_mux_pkg::PORTA_W-1:0] porta_in_o,
    output logic [port_abd_mux_pkg::PORTB_W-1:0] portb_in_o,
    output logic portd_in_o,
    // FIFO / GPIF side
    input wire logic [port_abd_mux_pkg::FIFO_DATA_W-1:0] fifo_wdata_i,
    input wire logic fifo_drive_i,
    output logic [port_abd_mux_pkg::FIFO_DATA_W-1:0] fifo_rdata_o,
    input wire logic fifo_flag_four_i,
    input wire logic [STROBE_W-1:0] slave_strobe_raw_i,
    output logic [STROBE_W-1:0] slave_strobe_gated_o,
    output logic slave_select_active_o,
    output logic packet_commit_o,
    // NAND firmware side
    input wire logic [port_abd_mux_pkg::PORTB_W-1:0] nand_wdata_i,
    input wire logic nand_drive_i,
    output logic [port_abd_mux_pkg::PORTB_W-1:0] nand_rdata_o,
    input wire logic nand_chip_enable_n_i,
    output logic [port_abd_mux_pkg::PORTA_W-1:0] fw_general_input_o,
    // Pins
    input wire logic porta_bit_six_i,
    output logic porta_bit_six_o,
    output logic porta_bit_six_oe_n_o,
    input wire logic porta_bit_seven_i,
    output logic porta_bit_seven_o,
    output logic porta_bit_seven_oe_n_o,
    input wire logic [port_abd_mux_pkg::PORTB_W-1:0] portb_pin_i,
    output logic [port_abd_mux_pkg::PORTB_W-1:0] portb_pin_o,
    output logic [port_abd_mux_pkg::PORTB_W-1:0] portb_pin_oe_n_o,
    input wire logic portd_pin_zero_i,
    output logic portd_pin_zero_o,
    output logic portd_pin_zero_oe_n_o
);
    import port_abd_mux_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [IFC_W-1:0] ifc;
        logic alt7;
        logic pol5;
        logic wide;
        logic nand_en;
        logic [PORTB_W-1:0] pb_out;
        logic [PORTB_W-1:0] pb_oe_n;
        logic [PORTA_W-1:0] pa_out;
        logic [PORTA_W-1:0] pa_oe_n;
        logic pd_out;
        logic pd_oe_n;
        logic commit_prev;
        logic commit_pulse;
    } mux_state_t;

    localparam mux_state_t STATE_RESET = '{
        ifc: IFC_RESET,
        alt7: ALT_CONFIG7_RESET,
        pol5: PIN_POLARITY5_RESET,
        wide: WORDWIDE_RESET,
        nand_en: NAND_MODE_RESET,
        pb_out: '0,
        pb_oe_n: '1,
        pa_out: '0,
        pa_oe_n: '1,
        pd_out: 1'h0,
        pd_oe_n: 1'h1,
        commit_prev: 1'h0,
        commit_pulse: 1'h0
    };

    mux_state_t state_q;
    mux_state_t state_d;

    // ************************************************************
    // Pin input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    logic pa6_s;
    logic pa7_s;
    logic [PORTB_W-1:0] pb_s;
    logic pd0_s;

    assign pins_raw = {portd_pin_zero_i, portb_pin_i, porta_bit_seven_i, porta_bit_six_i};

    pin_input_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .async_i(pins_raw),
        .sync_o(pins_sync)
    );

    assign pa6_s = pins_sync[SYNC_PA6];
    assign pa7_s = pins_sync[SYNC_PA7];
    assign pb_s = pins_sync[SYNC_PB_LSB +: PORTB_W];
    assign pd0_s = pins_sync[SYNC_PD0];

    // ************************************************************
    // Mode decode
    // ************************************************************
    pin_mode_t mode;
    logic fifo_mode;
    logic select_role;
    logic flag_role;
    logic select_active;
    logic commit_level;
    logic fifo_send;

    always_comb begin
        mode = decode_mode(state_q.ifc, state_q.nand_en);
        fifo_mode = (mode == MODE_GPIF) || (mode == MODE_SLAVE);
        flag_role = (mode == MODE_SLAVE) && state_q.alt7;
        select_role = (mode == MODE_SLAVE) && !state_q.alt7;
        select_active = !select_role || !pa7_s;
        commit_level = state_q.pol5 ? pa6_s : !pa6_s;
        fifo_send = fifo_drive_i && (mode == MODE_GPIF || select_active);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d = state_q;

        // Configuration capture
        if (cfg_load_i) begin
            state_d.ifc = cfg_interface_config_i;
            state_d.alt7 = cfg_porta_alt_config7_i;
            state_d.pol5 = cfg_fifo_pin_polarity5_i;
            state_d.wide = cfg_endpoint_wordwide_i;
            state_d.nand_en = cfg_nand_mode_i;
        end

        // Plain port behaviour as the baseline
        state_d.pb_out = portb_out_i;
        state_d.pb_oe_n = ~portb_dir_i;
        state_d.pa_out = porta_out_i;
        state_d.pa_oe_n = ~porta_dir_i;
        state_d.pd_out = portd_out_i;
        state_d.pd_oe_n = !portd_dir_i;

        unique case (mode)
            MODE_PORT: begin
            end
            MODE_NAND: begin
                state_d.pb_out = nand_wdata_i;
                state_d.pb_oe_n = {PORTB_W{!nand_drive_i}};
                state_d.pd_out = nand_chip_enable_n_i;
                state_d.pd_oe_n = 1'h0;
                state_d.pa_out = '0;
                state_d.pa_oe_n = '1;
            end
            MODE_GPIF, MODE_SLAVE: begin
                state_d.pb_out = fifo_wdata_i[PORTB_W-1:0];
                state_d.pb_oe_n = {PORTB_W{!fifo_send}};
                if (state_q.wide) begin
                    state_d.pd_out = fifo_wdata_i[FIFO_BIT_EIGHT];
                    state_d.pd_oe_n = !fifo_send;
                end
                if (mode == MODE_SLAVE) begin
                    state_d.pa_out = '0;
                    state_d.pa_oe_n = '1;
                    if (flag_role) begin
                        state_d.pa_out[PA_SEVEN] = fifo_flag_four_i;
                        state_d.pa_oe_n[PA_SEVEN] = 1'h0;
                    end
                end
            end
        endcase

        // Packet commit on the asserting edge of the commit input
        state_d.commit_prev = commit_level;
        state_d.commit_pulse = (mode == MODE_SLAVE) && select_active
            && commit_level && !state_q.commit_prev;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign active_mode_o = mode;
    assign porta_in_o = {pa7_s, pa6_s};
    assign portb_in_o = pb_s;
    assign portd_in_o = pd0_s;
    assign fifo_rdata_o = {pd0_s, pb_s};
    assign nand_rdata_o = pb_s;
    assign fw_general_input_o = {pa7_s, pa6_s};
    assign slave_select_active_o = (mode == MODE_SLAVE) && select_active;
    assign slave_strobe_gated_o = slave_select_active_o ? slave_strobe_raw_i : '0;
    assign packet_commit_o = state_q.commit_pulse;

    assign porta_bit_six_o = state_q.pa_out[PA_SIX];
    assign porta_bit_six_oe_n_o = state_q.pa_oe_n[PA_SIX];
    assign porta_bit_seven_o = state_q.pa_out[PA_SEVEN];
    assign porta_bit_seven_oe_n_o = state_q.pa_oe_n[PA_SEVEN];
    assign portb_pin_o = state_q.pb_out;
    assign portb_pin_oe_n_o = state_q.pb_oe_n;
    assign portd_pin_zero_o = state_q.pd_out;
    assign portd_pin_zero_oe_n_o = state_q.pd_oe_n;

endmodule

`default_nettype wire

// File: verif/port_abd_mux_checker.sv
// Assertion checker for the port A/B/D pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module port_abd_mux_checker #(
    parameter int STROBE_W = 4
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] active_mode_o,
    input wire logic [7:0] portb_dir_i,
    input wire logic portd_dir_i,
    input wire logic [8:0] fifo_wdata_i,
    input wire logic fifo_drive_i,
    input wire logic fifo_flag_four_i,
    input wire logic [STROBE_W-1:0] slave_strobe_raw_i,
    input wire logic [STROBE_W-1:0] slave_strobe_gated_o,
    input wire logic slave_select_active_o,
    input wire logic packet_commit_o,
    input wire logic nand_chip_enable_n_i,
    input wire logic porta_bit_six_oe_n_o,
    input wire logic porta_bit_seven_o,
    input wire logic porta_bit_seven_oe_n_o,
    input wire logic [7:0] portb_pin_o,
    input wire logic [7:0] portb_pin_oe_n_o,
    input wire logic portd_pin_zero_o,
    input wire logic portd_pin_zero_oe_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    property p_port;
        active_mode_o == 4'h1 |=> portb_pin_oe_n_o == ~$past(portb_dir_i)
            && portd_pin_zero_oe_n_o == ~$past(portd_dir_i);
    endproperty
    a_port: assert property (p_port) else $error("port drive wrong");
    property p_nand;
        active_mode_o == 4'h2 |=> !portd_pin_zero_oe_n_o && porta_bit_six_oe_n_o
            && porta_bit_seven_oe_n_o && portd_pin_zero_o == $past(nand_chip_enable_n_i);
    endproperty
    a_nand: assert property (p_nand) else $error("nand pins wrong");
    property p_send;
        active_mode_o == 4'h4 && fifo_drive_i |=> portb_pin_oe_n_o == 8'h00
            && portb_pin_o == $past(fifo_wdata_i[7:0]);
    endproperty
    a_send: assert property (p_send) else $error("fifo send wrong");
    property p_recv;
        active_mode_o[3:2] != 2'h0 && !fifo_drive_i |=> portb_pin_oe_n_o == 8'hFF;
    endproperty
    a_recv: assert property (p_recv) else $error("fifo not released");
    property p_pa6;
        active_mode_o == 4'h8 |=> porta_bit_six_oe_n_o;
    endproperty
    a_pa6: assert property (p_pa6) else $error("commit pin driven");
    property p_flag;
        $past(active_mode_o) == 4'h8 && !porta_bit_seven_oe_n_o
            |-> porta_bit_seven_o == $past(fifo_flag_four_i);
    endproperty
    a_flag: assert property (p_flag) else $error("flag wrong");
    property p_gate;
        slave_strobe_gated_o == (slave_select_active_o ? slave_strobe_raw_i : '0)
            && (!slave_select_active_o || active_mode_o == 4'h8);
    endproperty
    a_gate: assert property (p_gate) else $error("strobe gate wrong");
    property p_commit;
        packet_commit_o |-> $past(active_mode_o) == 4'h8 ##1 !packet_commit_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit pulse wrong");
endmodule
`default_nettype wire

// File: verif/ext_pin_partner.sv
// Far-side pin model: external FIFO master or NAND chips
`timescale 1ns/1ps
`default_nettype none
module ext_pin_partner (
    input wire logic mclk_i,
    input wire logic [10:0] dev_o_i,
    input wire logic [10:0] dev_oe_n_i,
    input wire logic [10:0] ext_en_i,
    input wire logic [10:0] ext_val_i,
    output logic [10:0] pin_o
);
    logic [10:0] last_q;
    always_ff @(posedge mclk_i) begin
        last_q <= pin_o;
    end
    // Device wins, then far side; an undriven pin shows its inverted last level
    always_comb begin
        for (int i = 0; i < 11; i++) begin
            pin_o[i] = !dev_oe_n_i[i] ? dev_o_i[i] : (ext_en_i[i] ? ext_val_i[i] : ~last_q[i]);
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_port_abd_function_mux.sv
// Testbench for the port A/B/D pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_port_abd_function_mux;
    import port_abd_mux_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ld = 1'b0;
    logic [5:0] cfg = 6'h00;
    logic [1:0] pa_dir = 2'h0;
    logic [7:0] pb_out = 8'h00, pb_dir = 8'hFF, nd_wd = 8'h00;
    logic pd_dir = 1'b0, f_drv = 1'b0, flag = 1'b0, nd_drv = 1'b0, ce_n = 1'b1;
    logic [8:0] f_wd = 9'h000;
    logic [3:0] strb = 4'hB;
    logic [10:0] ext = 11'h000;
    logic [10:0] pins;
    wire [10:0] dev_o, oe_n;
    logic [3:0] mode, gated;
    logic [8:0] f_rd;
    logic [7:0] pb_in, nd_rd;
    logic [1:0] fw_in, pa_in;
    logic sel, commit, pd_in;
    int checks = 0;
    int n_fail = 0;
    port_abd_function_mux port_abd_function_mux_inst (.mclk_i(clk), .arst_n_i(rst_n),
        .cfg_load_i(ld), .cfg_interface_config_i(cfg[5:4]), .cfg_porta_alt_config7_i(cfg[3]),
        .cfg_fifo_pin_polarity5_i(cfg[2]), .cfg_endpoint_wordwide_i(cfg[1]),
        .cfg_nand_mode_i(cfg[0]), .active_mode_o(mode), .porta_out_i(2'h3), .porta_dir_i(pa_dir),
        .portb_out_i(pb_out), .portb_dir_i(pb_dir), .portd_out_i(1'b0), .portd_dir_i(pd_dir),
        .porta_in_o(pa_in), .portb_in_o(pb_in), .portd_in_o(pd_in), .fifo_wdata_i(f_wd),
        .fifo_drive_i(f_drv), .fifo_rdata_o(f_rd), .fifo_flag_four_i(flag),
        .slave_strobe_raw_i(strb), .slave_strobe_gated_o(gated), .slave_select_active_o(sel),
        .packet_commit_o(commit), .nand_wdata_i(nd_wd), .nand_drive_i(nd_drv),
        .nand_rdata_o(nd_rd), .nand_chip_enable_n_i(ce_n), .fw_general_input_o(fw_in),
        .porta_bit_six_i(pins[0]), .porta_bit_six_o(dev_o[0]), .porta_bit_six_oe_n_o(oe_n[0]),
        .porta_bit_seven_i(pins[1]), .porta_bit_seven_o(dev_o[1]),
        .porta_bit_seven_oe_n_o(oe_n[1]), .portb_pin_i(pins[9:2]), .portb_pin_o(dev_o[9:2]),
        .portb_pin_oe_n_o(oe_n[9:2]), .portd_pin_zero_i(pins[10]),
        .portd_pin_zero_o(dev_o[10]), .portd_pin_zero_oe_n_o(oe_n[10]));
    ext_pin_partner ext_pin_partner_inst (.mclk_i(clk), .dev_o_i(dev_o), .dev_oe_n_i(oe_n),
        .ext_en_i(11'h7FF), .ext_val_i(ext), .pin_o(pins));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [5:0] c, input logic [3:0] exp_mode);
        cfg = c;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        chk(mode, exp_mode);
        tick(1);
    endtask
    task automatic t_port();
        pb_out = 8'hA5;
        pb_dir = 8'hF0;
        pa_dir = 2'h2;
        ext = {1'b1, 8'h03, 2'h0};
        tick(1);
        chk(oe_n[10:2], 9'h10F);
        chk({oe_n[1:0], dev_o[1]}, 3'h3);
        chk(dev_o[9:6], 4'hA);
        tick(2);
        chk(pb_in, 8'hA3);
        chk({pd_in, pa_in}, 3'h6);
    endtask
    task automatic t_gpif();
        f_wd = 9'h1A5;
        f_drv = 1'b1;
        load({IFC_GPIF, 4'h2}, 4'h4);
        chk(dev_o[10:2], 9'h1A5);
        chk(oe_n[10:2], 9'h000);
        f_drv = 1'b0;
        ext = {9'h05A, 2'h0};
        tick(3);
        chk(oe_n[10:2], 9'h1FF);
        chk(f_rd, 9'h05A);
        pd_dir = 1'b1;
        f_drv = 1'b1;
        load({IFC_GPIF, 4'h0}, 4'h4);
        chk({oe_n[10], dev_o[10]}, 2'h0);
    endtask
    task automatic t_nand();
        pd_dir = 1'b0;
        pa_dir = 2'h3;
        nd_wd = 8'h3C;
        nd_drv = 1'b1;
        ce_n = 1'b0;
        ext = 11'h002;
        load({IFC_RESERVED, 4'h1}, 4'h2);
        tick(2);
        chk({dev_o[10:2], oe_n}, 20'h1E003);
        chk(fw_in, 2'h2);
        nd_drv = 1'b0;
        ce_n = 1'b1;
        ext = {1'b0, 8'hC3, 2'h2};
        tick(3);
        chk(nd_rd, 8'hC3);
        chk(dev_o[10], 1'b1);
    endtask
    task automatic t_select();
        pa_dir = 2'h0;
        f_wd = 9'h0F0;
        f_drv = 1'b1;
        load({IFC_SLAVE_FIFO, 4'h0}, 4'h8);
        tick(2);
        chk({sel, gated}, 5'h00);
        chk(oe_n[9:0], 10'h3FF);
        ext = 11'h000;
        tick(3);
        chk({sel, gated}, 5'h1B);
        chk({oe_n[9:2], dev_o[9:2]}, 16'h00F0);
    endtask
    task automatic t_commit();
        int n;
        for (int p = 0; p < 3; p++) begin
            ext = {10'h000, ~p[0]};
            flag = p[0];
            load({p[1] ? IFC_GPIF : IFC_SLAVE_FIFO, 1'b1, p[0], 2'h0}, p[1] ? 4'h4 : 4'h8);
            tick(3);
            if (!p[1]) begin
                chk({oe_n[1], dev_o[1]}, {1'b0, p[0]});
            end
            n = 0;
            ext[0] = p[0];
            repeat (8) begin
                tick(1);
                n += (commit === 1'b1);
            end
            chk(n[15:0], p[1] ? 16'h0 : 16'h1);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        tick(12);
        chk(mode, 4'h1);
        chk(oe_n, 11'h7FF);
        rst_n = 1'b1;
        t_port();
        t_gpif();
        t_nand();
        t_select();
        t_commit();
        summarize();
    end
endmodule
bind port_abd_function_mux port_abd_mux_checker #(.STROBE_W(STROBE_W)) checker_inst (
    .mclk_i, .arst_n_i, .active_mode_o, .portb_dir_i, .portd_dir_i, .fifo_wdata_i,
    .fifo_drive_i, .fifo_flag_four_i, .slave_strobe_raw_i, .slave_strobe_gated_o,
    .slave_select_active_o, .packet_commit_o, .nand_chip_enable_n_i, .porta_bit_six_oe_n_o,
    .porta_bit_seven_o, .porta_bit_seven_oe_n_o, .portb_pin_o, .portb_pin_oe_n_o,
    .portd_pin_zero_o, .portd_pin_zero_oe_n_o);
`default_nettype wire
